// file: src/rx_filter_pkg.sv
/*
 * Constants for the receive frame acceptance block: register offsets, field layout,
 * reset values, frame sizes and descriptor flag positions.
 * Assumes a 32-bit Avalon-MM slave with word addresses and a single 100 MHz clock.
 */
// Summary of operation
// RQ1 - Pass-FCS clear: strip the four FCS bytes, leave them out of packet length.
// RQ2 - Pass-FCS set: write FCS to memory and count it in packet length.
// RQ3 - Receive QoS handling is on exactly while the QoS enable bit is one; QOS_EN_O follows the bit one cycle late.
// RQ4 - Single-buffer bit clear: one frame may span several linked buffers.
// RQ5 - Single-buffer bit set: frame goes in one buffer, overflow bytes discarded.
// RQ6 - Single-buffer mode reports the full frame byte count, up to 65535.
// RQ7 - Copy-control clear: control frames not written, yet still acted upon.
// RQ8 - Pause frames act whenever MAC control enables pause, whatever copy-control says.
// RQ9 - Copy-control set: control frames written, control flag set in EOP descriptor.
// RQ10 - Frames under 64 bytes are filtered unless copy-short is set.
// RQ11 - Copied short frame: fragment flag if errored, undersize flag if clean.
// RQ12 - Copy-error set: errored frames kept with error flag; clear: filtered.
// RQ13 - Copy-all set: unmatched frames go to promiscuous channel with no-match flag.
// RQ14 - Promiscuous frames go to the channel named by the three-bit select.
// RQ15 - Broadcast enable set: broadcast to its selected channel; clear: filtered.
// RQ16 - Reserved bits read zero, ignore writes; writable fields reset to zero.
// RQ17 - Multicast enable and select act like the broadcast pair.
`default_nettype none
package rx_filter_pkg;
	localparam logic [3:0] ADDR_FILTER_CTRL = 4'h0;
	localparam logic [3:0] ADDR_MAC_CTRL = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_ACCEPT_CNT = 4'h3;
	localparam logic [3:0] ADDR_DROP_CNT = 4'h4;
	localparam logic [31:0] FILTER_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] FILTER_CTRL_WMASK = 32'h71e7_2727;
	localparam logic [31:0] MAC_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] MAC_CTRL_WMASK = 32'h0000_0001;
	localparam int KEEP_FCS_BIT = 30;
	localparam int QOS_EN_BIT = 29;
	localparam int SINGLE_BUF_BIT = 28;
	localparam int COPY_CTRL_BIT = 24;
	localparam int COPY_SHORT_BIT = 23;
	localparam int COPY_ERR_BIT = 22;
	localparam int COPY_ALL_BIT = 21;
	localparam int PROM_CH_LSB = 16;
	localparam int BCAST_EN_BIT = 13;
	localparam int BCAST_CH_LSB = 8;
	localparam int MCAST_EN_BIT = 5;
	localparam int MCAST_CH_LSB = 0;
	localparam int PAUSE_EN_BIT = 0;
	localparam logic [15:0] MIN_FRAME_BYTES = 16'd64;
	localparam logic [15:0] FCS_BYTES = 16'd4;
	// Descriptor flag positions in the EOP status word
	localparam int FLG_CONTROL = 0;
	localparam int FLG_FRAGMENT = 1;
	localparam int FLG_UNDERSIZE = 2;
	localparam int FLG_ERROR = 3;
	localparam int FLG_NO_ADDRESS_MATCH_FLAG = 4;
	localparam int FLG_TRUNC = 5;
	localparam int FLAG_W = 6;
endpackage
`default_nettype wire

// file: src/rx_frame_filter.sv
/*
 * Receive frame acceptance and buffer handling for an Ethernet MAC.
 * Holds the filter control register and a MAC control register on Avalon-MM,
 * and classifies each frame summary into a drop/accept verdict with channel,
 * stored length, reported length and descriptor flags.
 * Assumes the parser upstream presents one frame summary per valid pulse,
 * and that the DMA downstream honours the single-buffer limit it is given.
 * Register writes land on the edge that takes the request, one cycle before the answer.
 */
`timescale 1ns/100ps
`default_nettype none
module rx_frame_filter (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// Avalon-MM slave
	input wire logic [3:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// Frame summary from the receive parser
	input wire logic FRM_VALID_I,
	input wire logic [15:0] FRM_LEN_I,
	input wire logic FRM_ERR_I,
	input wire logic FRM_CTRL_I,
	input wire logic FRM_PAUSE_I,
	input wire logic FRM_BCAST_I,
	input wire logic FRM_MCAST_I,
	input wire logic FRM_MATCH_I,
	input wire logic [2:0] FRM_MATCH_CH_I,
	input wire logic [15:0] BUF_SIZE_I,
	// Verdict to the receive DMA
	output logic VRD_VALID_O,
	output logic VRD_ACCEPT_O,
	output logic [2:0] VRD_CHANNEL_O,
	output logic [15:0] VRD_STORE_LEN_O,
	output logic [15:0] VRD_PKT_LEN_O,
	output logic VRD_STRIP_FCS_O,
	output logic VRD_CHAIN_O,
	output logic [5:0] VRD_FLAGS_O,
	output logic PAUSE_ACT_O,
	// Configuration levels
	output logic QOS_EN_O
);
	logic [31:0] filter_ctrl_reg, filter_ctrl_next;
	logic [31:0] mac_ctrl_reg, mac_ctrl_next;
	logic [31:0] rdata_reg, rdata_next;
	logic ack_reg, ack_next;
	logic [15:0] accept_cnt_reg, accept_cnt_next;
	logic [15:0] drop_cnt_reg, drop_cnt_next;
	logic vvalid_reg, vvalid_next;
	logic vaccept_reg, vaccept_next;
	logic [2:0] vch_reg, vch_next;
	logic [15:0] vstore_reg, vstore_next;
	logic [15:0] vpkt_reg, vpkt_next;
	logic vstrip_reg, vstrip_next;
	logic vchain_reg, vchain_next;
	logic [5:0] vflags_reg, vflags_next;
	logic pause_reg, pause_next;
	logic qos_reg, qos_next;
	logic [5:0] status_reg, status_next;
	logic cls_drop;
	logic [2:0] cls_ch;
	logic [5:0] cls_flags;
	logic [15:0] cls_pkt;
	logic [15:0] cls_store;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be, input logic [31:0] wmask);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
		merge_bytes = (old & ~m) | (wd & m);
	endfunction

	// Three-bit channel select field at a given position
	function automatic logic [2:0] ch_field(input logic [31:0] ctrl, input int lsb);
		ch_field = ctrl[lsb +: 3];
	endfunction

	// Counters wrap at 16 bits; software treats them as free-running totals
	function automatic logic [15:0] bump(input logic [15:0] cnt);
		bump = cnt + 16'h0001;
	endfunction

	// Handshake: one cycle of waitrequest, answer on the second edge
	always_comb begin
		ack_next = (AVS_READ_I | AVS_WRITE_I) & ~ack_reg;
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
		end
	end

	// Register file: a request is acted on at the edge that takes it
	always_comb begin
		logic req;
		req = (AVS_READ_I | AVS_WRITE_I) & ~ack_reg;
		filter_ctrl_next = filter_ctrl_reg;
		mac_ctrl_next = mac_ctrl_reg;
		rdata_next = rdata_reg;
		if (req && AVS_WRITE_I) begin
			unique case (AVS_ADDRESS_I)
				rx_filter_pkg::ADDR_FILTER_CTRL: filter_ctrl_next = merge_bytes(filter_ctrl_reg,
					AVS_WRITEDATA_I, AVS_BYTEENABLE_I, rx_filter_pkg::FILTER_CTRL_WMASK); // [RQ16]
				rx_filter_pkg::ADDR_MAC_CTRL: mac_ctrl_next = merge_bytes(mac_ctrl_reg,
					AVS_WRITEDATA_I, AVS_BYTEENABLE_I, rx_filter_pkg::MAC_CTRL_WMASK);
				default: ;
			endcase
		end
		if (req && AVS_READ_I) begin
			unique case (AVS_ADDRESS_I)
				rx_filter_pkg::ADDR_FILTER_CTRL: rdata_next = filter_ctrl_reg; // [RQ16]
				rx_filter_pkg::ADDR_MAC_CTRL: rdata_next = mac_ctrl_reg;
				rx_filter_pkg::ADDR_STATUS: rdata_next = {26'h0, status_reg};
				rx_filter_pkg::ADDR_ACCEPT_CNT: rdata_next = {16'h0, accept_cnt_reg};
				rx_filter_pkg::ADDR_DROP_CNT: rdata_next = {16'h0, drop_cnt_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			filter_ctrl_reg <= rx_filter_pkg::FILTER_CTRL_RESET; // [RQ16]
			mac_ctrl_reg <= rx_filter_pkg::MAC_CTRL_RESET;
			rdata_reg <= 32'h0000_0000;
		end else begin
			filter_ctrl_reg <= filter_ctrl_next;
			mac_ctrl_reg <= mac_ctrl_next;
			rdata_reg <= rdata_next;
		end
	end

	assign AVS_READDATA_O = rdata_reg;
	assign AVS_WAITREQUEST_O = ~ack_reg;

	// Frame decode of the summary now on the parser inputs
	always_comb begin
		logic keep_fcs, single, is_short, no_address_match_flag;
		keep_fcs = filter_ctrl_reg[rx_filter_pkg::KEEP_FCS_BIT];
		single = filter_ctrl_reg[rx_filter_pkg::SINGLE_BUF_BIT];
		is_short = FRM_LEN_I < rx_filter_pkg::MIN_FRAME_BYTES;
		no_address_match_flag = 1'b0;
		cls_drop = 1'b0;
		cls_flags = '0;
		cls_ch = FRM_MATCH_CH_I;
		cls_pkt = FRM_LEN_I;
		cls_store = FRM_LEN_I;
		// Length includes FCS only when it is kept; guards against runts under four bytes
		if (keep_fcs || FRM_LEN_I < rx_filter_pkg::FCS_BYTES) begin
			cls_pkt = FRM_LEN_I; // [RQ2]
		end else begin
			cls_pkt = FRM_LEN_I - rx_filter_pkg::FCS_BYTES; // [RQ1]
		end
		if (FRM_BCAST_I) begin
			cls_drop = ~filter_ctrl_reg[rx_filter_pkg::BCAST_EN_BIT]; // [RQ15]
			cls_ch = ch_field(filter_ctrl_reg, rx_filter_pkg::BCAST_CH_LSB);
		end else if (FRM_MCAST_I && FRM_MATCH_I) begin
			cls_drop = ~filter_ctrl_reg[rx_filter_pkg::MCAST_EN_BIT]; // [RQ17]
			cls_ch = ch_field(filter_ctrl_reg, rx_filter_pkg::MCAST_CH_LSB);
		end else if (!FRM_MATCH_I) begin
			cls_drop = 1'b1;
		end
		// With copy-all set, unmatched or disabled traffic falls to the promiscuous channel
		if (cls_drop && filter_ctrl_reg[rx_filter_pkg::COPY_ALL_BIT]) begin
			cls_drop = 1'b0; // [RQ13]
			no_address_match_flag = 1'b1;
			cls_ch = ch_field(filter_ctrl_reg, rx_filter_pkg::PROM_CH_LSB); // [RQ14]
		end
		cls_flags[rx_filter_pkg::FLG_NO_ADDRESS_MATCH_FLAG] = no_address_match_flag;
		if (FRM_CTRL_I) begin
			cls_drop = cls_drop | ~filter_ctrl_reg[rx_filter_pkg::COPY_CTRL_BIT]; // [RQ7]
			cls_flags[rx_filter_pkg::FLG_CONTROL] = 1'b1; // [RQ9]
		end
		if (is_short) begin
			cls_drop = cls_drop | ~filter_ctrl_reg[rx_filter_pkg::COPY_SHORT_BIT]; // [RQ10]
			cls_flags[rx_filter_pkg::FLG_FRAGMENT] = FRM_ERR_I; // [RQ11]
			cls_flags[rx_filter_pkg::FLG_UNDERSIZE] = ~FRM_ERR_I; // [RQ11]
		end else if (FRM_ERR_I) begin
			cls_drop = cls_drop | ~filter_ctrl_reg[rx_filter_pkg::COPY_ERR_BIT]; // [RQ12]
			cls_flags[rx_filter_pkg::FLG_ERROR] = 1'b1; // [RQ12]
		end
		// The descriptor keeps the full count even when the store is cut to one buffer
		if (single && cls_pkt > BUF_SIZE_I) begin
			cls_store = BUF_SIZE_I; // [RQ5]
			cls_flags[rx_filter_pkg::FLG_TRUNC] = 1'b1;
		end else begin
			cls_store = cls_pkt; // [RQ4]
		end
	end

	// Verdict fields hold until the next summary, so the DMA may take them late
	always_comb begin
		vvalid_next = FRM_VALID_I;
		vaccept_next = vaccept_reg;
		vch_next = vch_reg;
		vstore_next = vstore_reg;
		vpkt_next = vpkt_reg;
		vstrip_next = vstrip_reg;
		vchain_next = vchain_reg;
		vflags_next = vflags_reg;
		if (FRM_VALID_I) begin
			vaccept_next = ~cls_drop;
			vch_next = cls_ch;
			vstore_next = cls_store; // [RQ5]
			vpkt_next = cls_pkt; // [RQ6]
			vstrip_next = ~filter_ctrl_reg[rx_filter_pkg::KEEP_FCS_BIT]; // [RQ1]
			vchain_next = ~filter_ctrl_reg[rx_filter_pkg::SINGLE_BUF_BIT]; // [RQ4]
			// Flags describe stored frames only; a dropped frame leaves them clear
			vflags_next = cls_drop ? '0 : cls_flags;
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			vvalid_reg <= 1'b0;
			vaccept_reg <= 1'b0;
			vch_reg <= 3'h0;
			vstore_reg <= 16'h0000;
			vpkt_reg <= 16'h0000;
			vstrip_reg <= 1'b0;
			vchain_reg <= 1'b0;
			vflags_reg <= 6'h00;
		end else begin
			vvalid_reg <= vvalid_next;
			vaccept_reg <= vaccept_next;
			vch_reg <= vch_next;
			vstore_reg <= vstore_next;
			vpkt_reg <= vpkt_next;
			vstrip_reg <= vstrip_next;
			vchain_reg <= vchain_next;
			vflags_reg <= vflags_next;
		end
	end

	// Counted one cycle behind the verdict; a read may miss the frame just judged
	always_comb begin
		accept_cnt_next = accept_cnt_reg;
		drop_cnt_next = drop_cnt_reg;
		if (vvalid_reg && vaccept_reg) begin
			accept_cnt_next = bump(accept_cnt_reg);
		end
		if (vvalid_reg && !vaccept_reg) begin
			drop_cnt_next = bump(drop_cnt_reg);
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			accept_cnt_reg <= 16'h0000;
			drop_cnt_reg <= 16'h0000;
		end else begin
			accept_cnt_reg <= accept_cnt_next;
			drop_cnt_reg <= drop_cnt_next;
		end
	end

	// Status keeps the flags of the last stored frame, so a later drop does not hide them
	always_comb begin
		status_next = status_reg;
		if (vvalid_reg && vaccept_reg) begin
			status_next = vflags_reg;
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			status_reg <= 6'h00;
		end else begin
			status_reg <= status_next;
		end
	end

	// Pause acts regardless of the copy decision
	always_comb begin
		pause_next = FRM_VALID_I & FRM_PAUSE_I & mac_ctrl_reg[rx_filter_pkg::PAUSE_EN_BIT]; // [RQ8]
		qos_next = filter_ctrl_reg[rx_filter_pkg::QOS_EN_BIT]; // [RQ3]
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pause_reg <= 1'b0;
			qos_reg <= 1'b0;
		end else begin
			pause_reg <= pause_next;
			qos_reg <= qos_next;
		end
	end

	assign VRD_VALID_O = vvalid_reg;
	assign VRD_ACCEPT_O = vaccept_reg;
	assign VRD_CHANNEL_O = vch_reg;
	assign VRD_STORE_LEN_O = vstore_reg;
	assign VRD_PKT_LEN_O = vpkt_reg;
	assign VRD_STRIP_FCS_O = vstrip_reg;
	assign VRD_CHAIN_O = vchain_reg;
	assign VRD_FLAGS_O = vflags_reg;
	assign PAUSE_ACT_O = pause_reg;
	assign QOS_EN_O = qos_reg;
endmodule // rx_frame_filter
`default_nettype wire

// file: dv/rx_frame_filter_properties.sv
/* Properties of rx_frame_filter at its ports.
   Bound to every instance of the block; one clock, async reset. */
`timescale 1ns/100ps
`default_nettype none
module rx_frame_filter_properties (
	// Bus
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic [3:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	// Frames
	input wire logic FRM_VALID_I,
	input wire logic [15:0] FRM_LEN_I,
	input wire logic FRM_ERR_I,
	input wire logic FRM_PAUSE_I,
	input wire logic [15:0] BUF_SIZE_I,
	input wire logic VRD_VALID_O,
	input wire logic VRD_ACCEPT_O,
	input wire logic [15:0] VRD_STORE_LEN_O,
	input wire logic [15:0] VRD_PKT_LEN_O,
	input wire logic VRD_STRIP_FCS_O,
	input wire logic VRD_CHAIN_O,
	input wire logic [5:0] VRD_FLAGS_O,
	input wire logic PAUSE_ACT_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	sequence s_req;
		$rose(AVS_READ_I || AVS_WRITE_I);
	endsequence
	sequence s_kept;
		VRD_VALID_O && VRD_ACCEPT_O;
	endsequence
	a_bus_answer: assert property (
		s_req |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O) else $error("bus answer late");
	a_verdict_next: assert property (
		FRM_VALID_I |=> VRD_VALID_O) else $error("verdict missing");
	a_fcs_strip: assert property (
		s_kept ##0 VRD_STRIP_FCS_O && $past(FRM_LEN_I) > 16'h3
		|-> VRD_PKT_LEN_O == $past(FRM_LEN_I) - 16'h4) else $error("stripped length");
	a_fcs_keep: assert property (
		s_kept ##0 !VRD_STRIP_FCS_O |-> VRD_PKT_LEN_O == $past(FRM_LEN_I))
		else $error("kept length");
	a_chain_whole: assert property (
		s_kept ##0 VRD_CHAIN_O |-> VRD_STORE_LEN_O == VRD_PKT_LEN_O && !VRD_FLAGS_O[5])
		else $error("chained store");
	a_single_limit: assert property (
		s_kept ##0 !VRD_CHAIN_O && VRD_PKT_LEN_O > $past(BUF_SIZE_I)
		|-> VRD_STORE_LEN_O == $past(BUF_SIZE_I) && VRD_FLAGS_O[5]) else $error("single buffer");
	a_pause_cause: assert property (
		PAUSE_ACT_O |-> $past(FRM_VALID_I && FRM_PAUSE_I)) else $error("stray pause");
	a_short_flags: assert property (
		s_kept ##0 $past(FRM_LEN_I) < 16'h40
		|-> VRD_FLAGS_O[2:1] == {!$past(FRM_ERR_I), $past(FRM_ERR_I)}) else $error("short flags");
	a_reserved_zero: assert property (
		!AVS_WAITREQUEST_O && AVS_READ_I && AVS_ADDRESS_I == 4'h0
		|-> (AVS_READDATA_O & ~rx_filter_pkg::FILTER_CTRL_WMASK) == 32'h0) else $error("reserved");
	a_drop_flags: assert property (
		VRD_VALID_O && !VRD_ACCEPT_O |-> VRD_FLAGS_O == 6'h00) else $error("flags on drop");
endmodule // rx_frame_filter_properties
bind rx_frame_filter rx_frame_filter_properties u_props (.*);
`default_nettype wire

// file: dv/rx_parser_model.sv
/* Frame summary source standing in for the receive parser.
   Fields are inverted between frames, so stale values never look valid. */
`timescale 1ns/100ps
`default_nettype none
module rx_parser_model (
	// Clock
	input wire logic clk_i,
	// Frame summary
	output logic valid_o,
	output logic [15:0] len_o,
	output logic [5:0] kind_o,
	output logic [15:0] buf_o
);
	initial begin
		valid_o = 1'b0;
		len_o = 16'h0;
		kind_o = 6'h0;
		buf_o = 16'h0;
	end
	task automatic send(input logic [15:0] l, input logic [5:0] k, input logic [15:0] b);
		@(posedge clk_i);
		valid_o <= 1'b1;
		len_o <= l;
		kind_o <= k;
		buf_o <= b;
		@(posedge clk_i);
		valid_o <= 1'b0;
		len_o <= ~l;
		kind_o <= ~k;
		buf_o <= ~b;
	endtask
endmodule // rx_parser_model
`default_nettype wire

// file: dv/rx_frame_filter_tb.sv
/* Self-checking bench for rx_frame_filter.
   Assumes rx_parser_model as frame source; match channel fixed at 3. */
`timescale 1ns/100ps
`default_nettype none
module rx_frame_filter_tb;
	logic clk, rst_n, rd, wr, wreq, vv, acc, strip, chain, pse, qos, fv;
	logic [3:0] adr;
	logic [31:0] wd, rdat, q;
	logic [2:0] ch;
	logic [15:0] sl, pl, fl, bs;
	logic [5:0] flg, kd;
	int err_total, checks_done;
	rx_parser_model u_src (.clk_i(clk), .valid_o(fv), .len_o(fl), .kind_o(kd), .buf_o(bs));
	rx_frame_filter dut (.CLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdat),
		.AVS_WAITREQUEST_O(wreq), .FRM_VALID_I(fv), .FRM_LEN_I(fl), .FRM_ERR_I(kd[5]),
		.FRM_CTRL_I(kd[4]), .FRM_PAUSE_I(kd[3]), .FRM_BCAST_I(kd[2]), .FRM_MCAST_I(kd[1]),
		.FRM_MATCH_I(kd[0]), .FRM_MATCH_CH_I(3'h3), .BUF_SIZE_I(bs), .VRD_VALID_O(vv),
		.VRD_ACCEPT_O(acc), .VRD_CHANNEL_O(ch), .VRD_STORE_LEN_O(sl), .VRD_PKT_LEN_O(pl),
		.VRD_STRIP_FCS_O(strip), .VRD_CHAIN_O(chain), .VRD_FLAGS_O(flg), .PAUSE_ACT_O(pse),
		.QOS_EN_O(qos));
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 50) chk("waitrequest", wreq, 0);
	endtask
	task automatic fr(input logic [15:0] l, input logic [5:0] k, input logic [15:0] b,
		input logic a, input logic [2:0] c, input logic [5:0] f, input logic [15:0] p);
		u_src.send(l, k, b);
		#1;
		chk("valid", vv, 1);
		chk("accept", acc, a);
		if (a) begin
			chk("channel", ch, c);
			chk("flags", flg, f);
			chk("length", pl, p);
		end
	endtask
	task automatic t_regs;
		bus(4'h0, 0, 0);
		chk("ctrl reset", q, 0);
		bus(4'h0, 1, '1);
		bus(4'h0, 0, 0);
		chk("ctrl mask", q, rx_filter_pkg::FILTER_CTRL_WMASK);
		chk("qos on", qos, 1);
		bus(4'h0, 1, 0);
		@(posedge clk);
		#1;
		chk("qos off", qos, 0);
		bus(4'h9, 0, 0);
		chk("unmapped", q, 0);
	endtask
	task automatic t_fcs_chain;
		fr(16'd100, 6'h01, 16'd2000, 1, 3, 0, 16'd96);
		chk("strip", strip, 1);
		bus(4'h0, 1, 32'h4000_0000);
		fr(16'd1000, 6'h01, 16'd256, 1, 3, 0, 16'd1000);
		chk("chain", chain, 1);
		chk("stored", sl, 16'd1000);
		chk("strip", strip, 0);
		bus(4'h0, 1, 32'h5000_0000);
		fr(16'hffff, 6'h01, 16'd256, 1, 3, 6'h20, 16'hffff);
		chk("stored", sl, 16'd256);
		chk("chain", chain, 0);
	endtask
	// Control, short and errored frames: each copy bit off, then on
	task automatic t_copy;
		bus(4'h1, 1, 1);
		bus(4'h0, 1, 0);
		fr(16'd64, 6'h19, 16'd2000, 0, 0, 0, 0);
		chk("pause", pse, 1);
		fr(16'd63, 6'h01, 16'd2000, 0, 0, 0, 0);
		fr(16'd64, 6'h01, 16'd2000, 1, 3, 0, 16'd60);
		fr(16'd100, 6'h21, 16'd2000, 0, 0, 0, 0);
		bus(4'h0, 1, 32'h01c0_0000);
		fr(16'd64, 6'h19, 16'd2000, 1, 3, 6'h01, 16'd60);
		fr(16'd40, 6'h21, 16'd2000, 1, 3, 6'h02, 16'd36);
		fr(16'd40, 6'h01, 16'd2000, 1, 3, 6'h04, 16'd36);
		fr(16'd100, 6'h21, 16'd2000, 1, 3, 6'h08, 16'd96);
		bus(rx_filter_pkg::ADDR_STATUS, 0, 0);
		chk("status", q, 32'h0000_0008);
		bus(4'h1, 1, 0);
		fr(16'd64, 6'h19, 16'd2000, 1, 3, 6'h01, 16'd60);
		chk("pause", pse, 0);
	endtask
	task automatic t_route;
		for (int i = 0; i < 8; i++) begin
			bus(4'h0, 1, 32'h0020_0000 | (i << 16));
			fr(16'd100, 6'h00, 16'd2000, 1, i[2:0], 6'h10, 16'd96);
		end
		bus(4'h0, 1, 32'h0000_2526);
		fr(16'd100, 6'h04, 16'd2000, 1, 5, 0, 16'd96);
		fr(16'd100, 6'h03, 16'd2000, 1, 6, 0, 16'd96);
		bus(4'h0, 1, 0);
		fr(16'd100, 6'h04, 16'd2000, 0, 0, 0, 0);
		fr(16'd100, 6'h00, 16'd2000, 0, 0, 0, 0);
		bus(rx_filter_pkg::ADDR_ACCEPT_CNT, 0, 0);
		chk("accepted", q, 32'h0000_0013);
		bus(rx_filter_pkg::ADDR_DROP_CNT, 0, 0);
		chk("dropped", q, 32'h0000_0005);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Whole run is well under a thousand cycles
	initial begin
		#100000;
		err_total++;
		complete_run();
	end
	initial begin
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		adr = 4'h0;
		wd = 32'h0;
		err_total = 0;
		checks_done = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_fcs_chain();
		t_copy();
		t_route();
		complete_run();
	end
endmodule // rx_frame_filter_tb
`default_nettype wire
